// >>> logic/pms_pkg.sv
package pms_pkg;

  localparam int SUBSYS_W = 8;
  localparam int CPU_BIT = 0;
  localparam int FLASH_BIT = 1;
  localparam int AON_BIT = 7;
  localparam logic [7:0] ACT_TMPL_RST = 8'hFF;
  localparam logic [7:0] ALT_TMPL_RST = 8'hFC;
  localparam logic [7:0] SLEEP_KEEP = 8'h80;
  localparam logic [3:0] WAKE_EN_RST = 4'hF;
  localparam int SRC_PERIPH = 0;
  localparam int SRC_SUPERV = 1;
  localparam int SRC_TIMER = 2;
  localparam int SRC_PIN = 3;
  localparam int CLK_MHZ = 200;
  localparam int SLEEP_RESUME_US = 15;
  localparam int HIB_RESUME_US = 100;
  localparam int SLEEP_RESUME_CYC = SLEEP_RESUME_US * CLK_MHZ;
  localparam int HIB_RESUME_CYC = HIB_RESUME_US * CLK_MHZ - 1;
  localparam int BOOST_KHZ = 400;
  localparam int BOOST_HALF_CYC = (CLK_MHZ * 1000) / (BOOST_KHZ * 2);
  localparam int BOOST_MV_MIN = 1800;
  localparam int BOOST_MV_MAX = 5000;
  localparam int BOOST_MV_STEP = 100;
  localparam logic [5:0] BOOST_CODE_MAX = 6'h20;
  localparam int REFRESH_CYC_DEF = 4000;
  localparam int REFRESH_LEN_CYC = 64;

  typedef enum logic [1:0] {
    PMS_MODE_ACTIVE,
    PMS_MODE_ALT,
    PMS_MODE_SLEEP,
    PMS_MODE_HIB
  } pms_mode_t;

  typedef struct packed {
    logic periph;
    logic superv;
    logic timer;
    logic pin;
  } pms_irq_t;

  typedef struct packed {
    logic ext_reset;
    logic supervision;
    logic undervoltage;
  } pms_rst_t;

endpackage

// >>> logic/pms_sync.sv
`timescale 1ns/1ps
module pms_sync #(
  parameter int W = 1
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Asynchronous input and filtered result.
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;

  // A change is accepted only once the second and third stages agree.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_out <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < W; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          sync_out[i] <= s3_reg[i];
        end
      end
    end
  end

endmodule

// >>> logic/pms_sequencer.sv
`timescale 1ns/1ps
// How it works
// - Active template bits enable each subsystem but the processor, which halt and wakeup control.
// - Disabled subsystem has its clock gated.
// - Processor may halt itself; wakeup restarts it.
// - Wakeup forces active mode and processor on.
// - Boot leaves device in active mode.
// - Alternate active applies its own template.
// - Sleep resume completes within fifteen microseconds.
// - Hibernate holds state, outputs, pin settings.
// - Only pin interrupt ends hibernate.
// - Hibernate resume completes under one hundred microseconds.
// - Enabled interrupt or reset means wakeup.
// - Each interrupt wake source individually enabled.
// - Periodic wake timer raises regular interrupts.
// - Reset wake sources: pin, supervision, undervoltage.
// - Boost target 1.8 to 5.0 V, 100 mV.
// - Boost switches at 400 kHz internally.
// - Boost has active and standby modes.
// - Chip active modes keep boost active.
// - Sleep with standby boost wakes for refresh.
// - Sleep disables all but timer functions.
module pms_sequencer #(
  parameter int SUBSYS_W = pms_pkg::SUBSYS_W,
  parameter int SLEEP_RESUME_CYC = pms_pkg::SLEEP_RESUME_CYC,
  parameter int HIB_RESUME_CYC = pms_pkg::HIB_RESUME_CYC,
  parameter int TIMER_PERIOD_CYC = pms_pkg::REFRESH_CYC_DEF
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Firmware configuration.
  input wire logic [SUBSYS_W-1:0] active_template,
  input wire logic [SUBSYS_W-1:0] alt_template,
  input wire logic [3:0] wake_enable,
  input wire logic cpu_halt_req,
  input wire logic mode_req_valid,
  input wire pms_pkg::pms_mode_t mode_req,
  input wire logic [5:0] boost_target_code,
  input wire logic boost_standby_in_sleep,
  input wire logic timer_enable,
  // Wakeup sources from other logic on this clock.
  input wire pms_pkg::pms_irq_t irq_in,
  // Reset sources from pins and other domains.
  input wire pms_pkg::pms_rst_t reset_src,
  // Gated clocks to subsystems.
  input wire logic [SUBSYS_W-1:0] subsys_clock_in,
  output logic [SUBSYS_W-1:0] subsys_clock_out,
  // Status and control outputs.
  output logic [SUBSYS_W-1:0] subsys_enable,
  output logic cpu_enable,
  output pms_pkg::pms_mode_t mode,
  output logic resuming,
  output logic retain_hold,
  output logic wake_pulse,
  output logic timer_irq,
  output logic boost_active,
  output logic boost_switch,
  output logic [5:0] boost_code,
  output logic [12:0] boost_target_mv
);

  typedef enum logic [1:0] {
    PMS_SEQ_RUN,
    PMS_SEQ_RESUME,
    PMS_SEQ_LOW
  } pms_seq_t;

  pms_pkg::pms_mode_t mode_reg;
  pms_seq_t seq_reg;
  logic cpu_off_reg;
  logic [SUBSYS_W-1:0] enable_reg;
  logic [SUBSYS_W-1:0] clk_en_latch;
  logic [15:0] resume_cnt_reg;
  logic [31:0] timer_cnt_reg;
  logic timer_irq_reg;
  logic [9:0] boost_div_reg;
  logic boost_sw_reg;
  logic refresh_reg;
  logic [7:0] refresh_cnt_reg;
  logic [5:0] boost_code_reg;
  pms_pkg::pms_rst_t rst_sync;
  pms_pkg::pms_irq_t irq_gated;
  logic irq_wake;
  logic rst_wake;
  logic wake;
  logic low_req;

  // Reset sources arrive asynchronously and are filtered first.
  pms_sync #(
    .W(3)
  ) u_rst_sync (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(reset_src),
    .sync_out(rst_sync)
  );

  function automatic logic [SUBSYS_W-1:0] mode_enables(input pms_pkg::pms_mode_t m,
                                                        input logic [SUBSYS_W-1:0] act,
                                                        input logic [SUBSYS_W-1:0] alt);
    logic [SUBSYS_W-1:0] r;
    r = '0;
    case (m)
      pms_pkg::PMS_MODE_ACTIVE: r = act;
      pms_pkg::PMS_MODE_ALT: r = alt;
      pms_pkg::PMS_MODE_SLEEP: r = act & SUBSYS_W'(pms_pkg::SLEEP_KEEP);
      default: r = '0;
    endcase
    return r;
  endfunction

  assign irq_gated = irq_in & pms_pkg::pms_irq_t'(wake_enable);
  // Hibernate listens only to the pin interrupt; other modes to any enabled source.
  assign irq_wake = (mode_reg == pms_pkg::PMS_MODE_HIB) ? irq_gated.pin : (|irq_gated);
  assign rst_wake = (mode_reg != pms_pkg::PMS_MODE_HIB) && (|rst_sync);
  assign wake = irq_wake || rst_wake;
  assign low_req = mode_req_valid && (seq_reg == PMS_SEQ_RUN);

  // Global mode: wakeup wins over any concurrent firmware request.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mode_reg <= pms_pkg::PMS_MODE_ACTIVE;
    end else if (wake && mode_reg != pms_pkg::PMS_MODE_ACTIVE) begin
      mode_reg <= pms_pkg::PMS_MODE_ACTIVE;
    end else if (low_req && !wake) begin
      mode_reg <= mode_req;
    end
  end

  // Resume sequencing after leaving sleep or hibernate.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seq_reg <= PMS_SEQ_RUN;
      resume_cnt_reg <= '0;
    end else begin
      case (seq_reg)
        PMS_SEQ_RUN: begin
          if (low_req && !wake &&
              (mode_req == pms_pkg::PMS_MODE_SLEEP || mode_req == pms_pkg::PMS_MODE_HIB)) begin
            seq_reg <= PMS_SEQ_LOW;
          end
        end
        PMS_SEQ_LOW: begin
          if (wake) begin
            seq_reg <= PMS_SEQ_RESUME;
            // The fixed wait models regulator settling before running again.
            resume_cnt_reg <= (mode_reg == pms_pkg::PMS_MODE_HIB) ?
                              16'(HIB_RESUME_CYC) : 16'(SLEEP_RESUME_CYC);
          end
        end
        PMS_SEQ_RESUME: begin
          if (resume_cnt_reg <= 16'h0001) begin
            seq_reg <= PMS_SEQ_RUN;
            resume_cnt_reg <= '0;
          end else begin
            resume_cnt_reg <= resume_cnt_reg - 16'h0001;
          end
        end
        default: seq_reg <= PMS_SEQ_RUN;
      endcase
    end
  end

  // Processor self-halt, undone by any wakeup.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpu_off_reg <= 1'b0;
    end else if (wake) begin
      cpu_off_reg <= 1'b0;
    end else if (cpu_halt_req) begin
      cpu_off_reg <= 1'b1;
    end
  end

  // Subsystem enables; hibernate freezes everything at zero while state is held.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= pms_pkg::ACT_TMPL_RST;
    end else if (seq_reg == PMS_SEQ_RESUME) begin
      enable_reg <= '0;
    end else begin
      enable_reg <= mode_enables(mode_reg, active_template, alt_template);
      if (mode_reg == pms_pkg::PMS_MODE_ACTIVE && !cpu_off_reg && !wake) begin
        enable_reg[pms_pkg::CPU_BIT] <= 1'b1;
      end
      if (cpu_off_reg) begin
        enable_reg[pms_pkg::CPU_BIT] <= 1'b0;
      end
    end
  end

  // Glitch-free clock gates: enable latched while each clock is low.
  always_latch begin
    for (int i = 0; i < SUBSYS_W; i++) begin
      if (!subsys_clock_in[i]) begin
        clk_en_latch[i] = enable_reg[i];
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < SUBSYS_W; g++) begin : g_gate
      assign subsys_clock_out[g] = subsys_clock_in[g] & clk_en_latch[g];
    end
  endgenerate

  // Periodic wake timer, kept running through sleep.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      timer_cnt_reg <= '0;
      timer_irq_reg <= 1'b0;
    end else if (!timer_enable || mode_reg == pms_pkg::PMS_MODE_HIB) begin
      timer_cnt_reg <= '0;
      timer_irq_reg <= 1'b0;
    end else if (timer_cnt_reg >= 32'(TIMER_PERIOD_CYC - 1)) begin
      timer_cnt_reg <= '0;
      timer_irq_reg <= 1'b1;
    end else begin
      timer_cnt_reg <= timer_cnt_reg + 32'h00000001;
      timer_irq_reg <= 1'b0;
    end
  end

  // Boost refresh window: standby boost in sleep is brought active on each tick.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      refresh_reg <= 1'b0;
      refresh_cnt_reg <= '0;
    end else if (mode_reg != pms_pkg::PMS_MODE_SLEEP) begin
      refresh_reg <= 1'b0;
      refresh_cnt_reg <= '0;
    end else if (timer_irq_reg && boost_standby_in_sleep) begin
      refresh_reg <= 1'b1;
      refresh_cnt_reg <= 8'(pms_pkg::REFRESH_LEN_CYC - 1);
    end else if (refresh_cnt_reg != 8'h00) begin
      refresh_cnt_reg <= refresh_cnt_reg - 8'h01;
    end else begin
      refresh_reg <= 1'b0;
    end
  end

  // Boost mode follows chip mode; hibernate keeps it off only while standby boost is set.
  always_comb begin
    case (mode_reg)
      pms_pkg::PMS_MODE_ACTIVE: boost_active = 1'b1;
      pms_pkg::PMS_MODE_ALT: boost_active = 1'b1;
      pms_pkg::PMS_MODE_SLEEP: boost_active = !boost_standby_in_sleep || refresh_reg;
      default: boost_active = !boost_standby_in_sleep;
    endcase
    if (seq_reg == PMS_SEQ_RESUME) begin
      boost_active = 1'b1;
    end
  end

  // Target code saturates at the top of the 1.8 V to 5.0 V range.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boost_code_reg <= '0;
    end else if (boost_target_code > pms_pkg::BOOST_CODE_MAX) begin
      boost_code_reg <= pms_pkg::BOOST_CODE_MAX;
    end else begin
      boost_code_reg <= boost_target_code;
    end
  end

  // Switching tick from a divider of its own, not from a gated clock.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      boost_div_reg <= '0;
      boost_sw_reg <= 1'b0;
    end else if (!boost_active) begin
      boost_div_reg <= '0;
      boost_sw_reg <= 1'b0;
    end else if (boost_div_reg >= 10'(pms_pkg::BOOST_HALF_CYC - 1)) begin
      boost_div_reg <= '0;
      boost_sw_reg <= !boost_sw_reg;
    end else begin
      boost_div_reg <= boost_div_reg + 10'h001;
    end
  end

  assign subsys_enable = enable_reg;
  assign cpu_enable = enable_reg[pms_pkg::CPU_BIT];
  assign mode = mode_reg;
  assign resuming = (seq_reg == PMS_SEQ_RESUME);
  // Pads and retention cells hold while hibernating.
  assign retain_hold = (mode_reg == pms_pkg::PMS_MODE_HIB);
  assign wake_pulse = wake && (mode_reg != pms_pkg::PMS_MODE_ACTIVE);
  assign timer_irq = timer_irq_reg;
  assign boost_switch = boost_sw_reg;
  assign boost_code = boost_code_reg;
  assign boost_target_mv = 13'(pms_pkg::BOOST_MV_MIN) + 13'(boost_code_reg) * 13'(pms_pkg::BOOST_MV_STEP);

endmodule

// >>> dv/pms_assertions.sv
`timescale 1ns/1ps
module pms_assertions #(
  parameter int SLEEP_RESUME_CYC = 30,
  parameter int HIB_RESUME_CYC = 40,
  parameter int TIMER_PERIOD_CYC = 50
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rst_b,
  // Watched inputs.
  input wire logic [7:0] active_template,
  input wire logic [7:0] alt_template,
  input wire logic mode_req_valid,
  input wire logic timer_enable,
  input wire pms_pkg::pms_irq_t irq_in,
  // Watched outputs.
  input wire logic [7:0] subsys_clock_out,
  input wire logic [7:0] subsys_enable,
  input wire logic cpu_enable,
  input wire pms_pkg::pms_mode_t mode,
  input wire logic resuming,
  input wire logic wake_pulse,
  input wire logic timer_irq,
  input wire logic boost_active,
  input wire logic [5:0] boost_code,
  input wire logic [12:0] boost_target_mv
);
  int res_cnt;
  int gap_cnt;
  logic from_hib;
  logic gap_ok;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      res_cnt <= 0;
      from_hib <= 1'b0;
    end else begin
      res_cnt <= resuming ? res_cnt + 1 : 0;
      if (mode == pms_pkg::PMS_MODE_HIB || mode == pms_pkg::PMS_MODE_SLEEP) begin
        from_hib <= (mode == pms_pkg::PMS_MODE_HIB);
      end
    end
  end
  // The gap is only trusted while the timer stays enabled between two pulses.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      gap_cnt <= 0;
      gap_ok <= 1'b0;
    end else begin
      gap_cnt <= timer_irq ? 0 : gap_cnt + 1;
      gap_ok <= timer_enable && (gap_ok || timer_irq);
    end
  end
  sequence s_low_wake;
    (mode == pms_pkg::PMS_MODE_SLEEP || mode == pms_pkg::PMS_MODE_HIB) && wake_pulse;
  endsequence
  sequence s_back;
    mode == pms_pkg::PMS_MODE_ACTIVE && resuming;
  endsequence
  boost_in_run_a: assert property (mode inside {pms_pkg::PMS_MODE_ACTIVE, pms_pkg::PMS_MODE_ALT} |-> boost_active)
    else $error("boost not active in a run mode");
  wake_return_a: assert property (s_low_wake |=> s_back)
    else $error("wake did not return to active");
  hib_pin_only_a: assert property (mode == pms_pkg::PMS_MODE_HIB && !irq_in.pin |=> mode == pms_pkg::PMS_MODE_HIB)
    else $error("hibernate left without pin interrupt");
  sleep_gating_a: assert property (mode == pms_pkg::PMS_MODE_SLEEP && $past(mode) == pms_pkg::PMS_MODE_SLEEP
    |-> (subsys_enable & ~pms_pkg::SLEEP_KEEP) == 8'h00)
    else $error("subsystem left on in sleep");
  act_template_a: assert property (mode == pms_pkg::PMS_MODE_ACTIVE && $past(mode) == pms_pkg::PMS_MODE_ACTIVE
    && !resuming && !$past(resuming) && !$past(resuming, 2) |-> (subsys_enable >> 1) == ($past(active_template) >> 1))
    else $error("enables differ from active template");
  alt_template_a: assert property (mode == pms_pkg::PMS_MODE_ALT && $past(mode) == pms_pkg::PMS_MODE_ALT
    |-> (subsys_enable >> 1) == ($past(alt_template) >> 1))
    else $error("enables differ from alternate template");
  gated_clock_a: assert property ((subsys_clock_out & ~subsys_enable & ~$past(subsys_enable)) == 8'h00)
    else $error("clock runs to a disabled subsystem");
  cpu_after_wake_a: assert property ($fell(resuming) |-> ##[0:2] cpu_enable)
    else $error("processor not enabled after wake");
  resume_len_a: assert property ($fell(resuming)
    |-> res_cnt == (from_hib ? HIB_RESUME_CYC : SLEEP_RESUME_CYC))
    else $error("resume length wrong");
  timer_gap_a: assert property (timer_irq && gap_ok |-> gap_cnt == TIMER_PERIOD_CYC - 1)
    else $error("wake timer period wrong");
  boost_mv_a: assert property (boost_code <= 6'h20 && boost_target_mv == 13'(1800 + 100 * boost_code))
    else $error("boost target voltage wrong");
  low_entry_a: assert property ($changed(mode) && mode != pms_pkg::PMS_MODE_ACTIVE |-> $past(mode_req_valid))
    else $error("low power entry without request");
endmodule
bind pms_sequencer pms_assertions #(.SLEEP_RESUME_CYC(SLEEP_RESUME_CYC), .HIB_RESUME_CYC(HIB_RESUME_CYC),
  .TIMER_PERIOD_CYC(TIMER_PERIOD_CYC)) u_chk (.clock(clock), .rst_b(rst_b), .active_template(active_template),
  .alt_template(alt_template), .mode_req_valid(mode_req_valid), .timer_enable(timer_enable), .irq_in(irq_in),
  .subsys_clock_out(subsys_clock_out), .subsys_enable(subsys_enable), .cpu_enable(cpu_enable), .mode(mode),
  .resuming(resuming), .wake_pulse(wake_pulse), .timer_irq(timer_irq), .boost_active(boost_active),
  .boost_code(boost_code), .boost_target_mv(boost_target_mv));

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] act_t = 8'hFF;
  logic [7:0] alt_t = 8'hFC;
  logic [3:0] wake_en = 4'hF;
  logic halt = 1'b0;
  logic req_v = 1'b0;
  pms_pkg::pms_mode_t req_m = pms_pkg::PMS_MODE_ACTIVE;
  logic [5:0] code = 6'h00;
  logic tmr_en = 1'b0;
  pms_pkg::pms_irq_t irq = '0;
  pms_pkg::pms_rst_t rsrc = '0;
  logic [7:0] sclk_in = 8'h00;
  logic [7:0] sclk_out, en;
  logic cpu_en, resuming, retain, wake, tirq, b_act, b_sw;
  pms_pkg::pms_mode_t mode;
  pms_pkg::pms_mode_t exp_mode;
  logic [5:0] b_code;
  logic [12:0] b_mv;
  int n_errors = 0;
  int comparisons = 0;
  int seed = 32'h0705;
  int k, n;
  // Short counts keep the run brief; the timer and resume expectations derive from these.
  pms_sequencer #(.SLEEP_RESUME_CYC(30), .HIB_RESUME_CYC(40), .TIMER_PERIOD_CYC(50)) u_dut (.clock(clock),
    .rst_b(rst_b), .active_template(act_t), .alt_template(alt_t), .wake_enable(wake_en), .cpu_halt_req(halt),
    .mode_req_valid(req_v), .mode_req(req_m), .boost_target_code(code), .boost_standby_in_sleep(1'b1),
    .timer_enable(tmr_en), .irq_in(irq), .reset_src(rsrc), .subsys_clock_in(sclk_in), .subsys_clock_out(sclk_out),
    .subsys_enable(en), .cpu_enable(cpu_en), .mode(mode), .resuming(resuming), .retain_hold(retain),
    .wake_pulse(wake), .timer_irq(tirq), .boost_active(b_act), .boost_switch(b_sw), .boost_code(b_code),
    .boost_target_mv(b_mv));
  initial begin
    forever #2.5 clock = ~clock;
  end
  task automatic report_and_stop;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) begin
      @(posedge clock);
      // A free-running subsystem clock; a random one could sit high for cycles and hide late gating.
      #1 sclk_in = ~sclk_in;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (e !== g) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic req(input pms_pkg::pms_mode_t m);
    req_v = 1'b1;
    req_m = m;
    cyc(1);
    req_v = 1'b0;
    exp_mode = m;
    cyc(1);
    chk("mode", exp_mode, mode);
  endtask
  // Reset sources pass a synchroniser, so the return to active may lag a few cycles.
  task automatic resume;
    int i;
    cyc(1);
    for (i = 0; i < 10 && mode !== pms_pkg::PMS_MODE_ACTIVE; i++) cyc(1);
    exp_mode = pms_pkg::PMS_MODE_ACTIVE;
    chk("mode", exp_mode, mode);
    chk("resuming", 1, resuming);
    irq = '0;
    rsrc = '0;
    for (i = 0; i < 200 && resuming !== 1'b0; i++) cyc(1);
    cyc(2);
    chk("cpu_enable", 1, cpu_en);
  endtask
  initial begin
    exp_mode = pms_pkg::PMS_MODE_ACTIVE;
    cyc(8);
    rst_b = 1'b1;
    cyc(1);
    chk("mode", exp_mode, mode);
    chk("enables", 8'hFF, en);
    chk("boost_active", 1, b_act);
    for (k = 0; k < 3; k++) begin
      act_t = 8'($random(seed));
      code = 6'($unsigned($random(seed)) % 33);
      cyc(3);
      chk("enables", act_t >> 1, en >> 1);
      chk("boost_mv", 1800 + 100 * code, b_mv);
      chk("boost_code", code, b_code);
    end
    tmr_en = 1'b1;
    cyc(60);
    n = 0;
    for (k = 0; k < 200; k++) begin
      cyc(1);
      n += (tirq === 1'b1);
    end
    chk("timer_pulses", 4, n);
    tmr_en = 1'b0;
    act_t = 8'($random(seed)) | 8'h01;
    halt = 1'b1;
    cyc(1);
    halt = 1'b0;
    cyc(2);
    chk("cpu_enable", 0, cpu_en);
    act_t = act_t & 8'hFE;
    alt_t = 8'($random(seed)) & 8'hFC;
    req(pms_pkg::PMS_MODE_ALT);
    cyc(1);
    chk("enables", alt_t >> 1, en >> 1);
    chk("boost_active", 1, b_act);
    for (k = 0; k < 4; k++) begin
      wake_en = 4'h0;
      req(pms_pkg::PMS_MODE_SLEEP);
      irq = pms_pkg::pms_irq_t'(4'hF);
      cyc(4);
      chk("mode", exp_mode, mode);
      chk("enables", 0, en & 8'h7F);
      wake_en = 4'(1 << k);
      resume();
    end
    wake_en = 4'hF;
    tmr_en = 1'b1;
    for (k = 0; k < 3; k++) begin
      req(pms_pkg::PMS_MODE_SLEEP);
      n = 0;
      for (int j = 0; j < 60; j++) begin
        cyc(1);
        n += (b_act === 1'b1);
      end
      chk("boost_refresh", 1, n > 0);
      rsrc = pms_pkg::pms_rst_t'(3'(1 << k));
      resume();
    end
    tmr_en = 1'b0;
    req(pms_pkg::PMS_MODE_HIB);
    irq = pms_pkg::pms_irq_t'(4'hE);
    rsrc = pms_pkg::pms_rst_t'(3'h7);
    cyc(10);
    chk("mode", exp_mode, mode);
    chk("retain_hold", 1, retain);
    chk("boost_active", 0, b_act);
    chk("boost_switch", 0, b_sw);
    rsrc = '0;
    irq = pms_pkg::pms_irq_t'(4'h1);
    resume();
    report_and_stop();
  end
  initial begin
    #50000;
    n_errors++;
    report_and_stop();
  end
endmodule
